// [shared/power_mgmt_control_status_pkg.sv]
// Purpose: Constants and carrier types for the PCI power management register block
// Assumes: Configuration access arrives as a simple one-cycle strobe with a byte offset
// Notes: Offsets are within the power management capability structure
package power_mgmt_control_status_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CAP_OFFSET = 8'h02;
  localparam logic [7:0] CSR_OFFSET = 8'h04;

  // ----------------------------------------
  // Capability field positions and values
  // ----------------------------------------
  localparam int CAP_D1_BIT = 9;
  localparam logic [2:0] CAP_AUX_CURRENT = 3'h0;
  localparam logic CAP_DSI_VALUE = 1'h1;
  localparam logic [2:0] CAP_VERSION = 3'h2;

  // ----------------------------------------
  // Control/status field positions and values
  // ----------------------------------------
  localparam int CSR_STATUS_BIT = 15;
  localparam int CSR_SCALE_LSB = 13;
  localparam int CSR_SELECT_LSB = 9;
  localparam int CSR_ENABLE_BIT = 8;
  localparam logic [1:0] SCALE_TENTH_WATT = 2'h1;
  localparam logic [1:0] SCALE_UNKNOWN = 2'h0;
  localparam logic [3:0] SELECT_RESET = 4'h0;

  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [1:0] {
    POWER_MGMT_CONTROL_STATUS_D0 = 2'b00,
    POWER_MGMT_CONTROL_STATUS_D1 = 2'b01,
    POWER_MGMT_CONTROL_STATUS_D2 = 2'b10,
    POWER_MGMT_CONTROL_STATUS_D3 = 2'b11
  } power_mgmt_control_status_state_t;

  // ----------------------------------------
  // Configuration access carrier
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [15:0] wdata;
  } power_mgmt_control_status_cfg_req_t;

  // Straps loaded from the EEPROM at power up
  typedef struct packed {
    logic pm_enable;
    logic manage_enable;
    logic clock_needed_valid;
    logic clock_needed;
  } power_mgmt_control_status_strap_t;

endpackage

// [logic/power_mgmt_control_status_regs.sv]
// Operation
// - D1 support bit reads constant zero.
// - Auxiliary current field reads zero.
// - Device specific initialization bit reads one.
// - Clock reliance bit comes from EEPROM, zero when not loaded.
// - Version field reads fixed code 010b.
// - Wake status flag sets on any wake condition, regardless of enable.
// - Writing one clears wake status and drops wake output; zero leaves it.
// - Aux power high: status cleared only by power good; else also bus reset.
// - Data scale reads 01b when managed and select is 0,3,4,7.
// - Data select resets zero, writable only with power management enabled.
// - Wake enable set allows filtered wake events to assert wake output.
// - With power management disabled, wake enable stays zero.
// - Wake enable clears at power on; bus reset clears it without aux power.
// - Legacy magic wake may assert the wake output with enable zero.
// - Power state D0=00b, D3=11b; unsupported writes are discarded.
//
// Purpose: PCI power management capability and control/status registers
// Assumes: arst_n is the network power good reset; bus_rst_n is the PCI bus reset level
// Notes: Wake output is active high; the pad inverts it onto the open-drain pin
// Notes: Wake status and enable survive a bus reset while auxiliary power is up
// Notes: Data scale is decoded, not stored, so it follows the manageability strap
`timescale 1ns/10ps
module power_mgmt_control_status_regs (
  // Clock and resets
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus_rst_n,
  // Configuration access
  input wire power_mgmt_control_status_pkg::power_mgmt_control_status_cfg_req_t cfg_req,
  output logic [15:0] cfg_rdata,
  output logic cfg_ack,
  // Straps and inputs
  input wire power_mgmt_control_status_pkg::power_mgmt_control_status_strap_t strap,
  input wire logic aux_power,
  input wire logic wake_event,
  input wire logic legacy_magic_wake,
  input wire logic magic_packet_seen,
  // Wake output and power state
  output logic wake_out,
  output logic [1:0] power_state_field
);

  logic bus_rst_q;
  logic bus_rise;
  logic wake_status_flag;
  logic wake_enable_bit;
  logic [3:0] data_select;
  logic [1:0] data_scale;
  logic [15:0] cap_word;
  logic [15:0] csr_word;
  logic wr_csr;
  logic wake_cond;
  logic rd_cap;
  logic rd_csr;
  logic clr_status;
  logic bus_clear_sticky;
  logic wake_gate;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic scale_known(input logic [3:0] sel);
    scale_known = (sel == 4'h0) || (sel == 4'h3) || (sel == 4'h4) || (sel == 4'h7);
  endfunction

  // Offset decode shared by the write path and the read mux
  function automatic logic hits_cap(input logic [7:0] off);
    hits_cap = (off == power_mgmt_control_status_pkg::CAP_OFFSET);
  endfunction

  function automatic logic hits_csr(input logic [7:0] off);
    hits_csr = (off == power_mgmt_control_status_pkg::CSR_OFFSET);
  endfunction

  function automatic logic state_supported(input logic [1:0] st);
    state_supported = (st == power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D0) || (st == power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D3);
  endfunction

  // ----------------------------------------
  // Bus reset edge
  // ----------------------------------------
  // Idle high, so leaving power good reset does not look like a bus reset edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rst_q <= 1'h1;
    end else begin
      bus_rst_q <= bus_rst_n;
    end
  end

  assign bus_rise = bus_rst_n && !bus_rst_q;
  // Without auxiliary power the sticky wake bits are lost on bus reset
  assign bus_clear_sticky = bus_rise && !aux_power;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  assign wr_csr = cfg_req.wr && hits_csr(cfg_req.offset);
  assign rd_cap = cfg_req.rd && hits_cap(cfg_req.offset);
  assign rd_csr = cfg_req.rd && hits_csr(cfg_req.offset);
  assign clr_status = wr_csr && cfg_req.wdata[power_mgmt_control_status_pkg::CSR_STATUS_BIT];
  // Magic packets count only while legacy wake is on
  assign wake_cond = wake_event || (legacy_magic_wake && magic_packet_seen);

  // ----------------------------------------
  // Wake status
  // ----------------------------------------
  // A wake in the same cycle as a clear wins, so no wake event is lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_status_flag <= 1'h0;
    end else if (wake_cond) begin
      wake_status_flag <= 1'h1;
    end else if (clr_status) begin
      wake_status_flag <= 1'h0;
    end else if (bus_clear_sticky) begin
      wake_status_flag <= 1'h0;
    end
  end

  // ----------------------------------------
  // Wake enable
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_enable_bit <= 1'h0;
    end else if (!strap.pm_enable) begin
      wake_enable_bit <= 1'h0;
    end else if (bus_clear_sticky) begin
      wake_enable_bit <= 1'h0;
    end else if (wr_csr) begin
      wake_enable_bit <= cfg_req.wdata[power_mgmt_control_status_pkg::CSR_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // Data select and power state
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_select <= power_mgmt_control_status_pkg::SELECT_RESET;
    end else if (wr_csr && strap.pm_enable) begin
      data_select <= cfg_req.wdata[power_mgmt_control_status_pkg::CSR_SELECT_LSB +: 4];
    end
  end

  // Power state returns to D0 after bus reset regardless of aux power
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_state_field <= power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D0;
    end else if (bus_rise) begin
      power_state_field <= power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D0;
    end else if (wr_csr && strap.pm_enable && state_supported(cfg_req.wdata[1:0])) begin
      case (cfg_req.wdata[1:0])
        power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D0: power_state_field <= power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D0;
        power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D3: power_state_field <= power_mgmt_control_status_pkg::POWER_MGMT_CONTROL_STATUS_D3;
        default: power_state_field <= power_state_field;
      endcase
    end
  end

  // ----------------------------------------
  // Capability word
  // ----------------------------------------
  always_comb begin
    cap_word = 16'h0000;
    cap_word[power_mgmt_control_status_pkg::CAP_D1_BIT] = 1'h0;
    cap_word[8:6] = power_mgmt_control_status_pkg::CAP_AUX_CURRENT;
    cap_word[5] = power_mgmt_control_status_pkg::CAP_DSI_VALUE;
    cap_word[4] = 1'h0;
    cap_word[3] = strap.clock_needed_valid && strap.clock_needed;
    cap_word[2:0] = power_mgmt_control_status_pkg::CAP_VERSION;
  end

  // ----------------------------------------
  // Control/status word
  // ----------------------------------------
  assign data_scale = (strap.manage_enable && scale_known(data_select)) ?
    power_mgmt_control_status_pkg::SCALE_TENTH_WATT : power_mgmt_control_status_pkg::SCALE_UNKNOWN;

  always_comb begin
    csr_word = 16'h0000;
    csr_word[power_mgmt_control_status_pkg::CSR_STATUS_BIT] = wake_status_flag;
    csr_word[power_mgmt_control_status_pkg::CSR_SCALE_LSB +: 2] = data_scale;
    csr_word[power_mgmt_control_status_pkg::CSR_SELECT_LSB +: 4] = data_select;
    csr_word[power_mgmt_control_status_pkg::CSR_ENABLE_BIT] = wake_enable_bit;
    csr_word[1:0] = power_state_field;
  end

  // ----------------------------------------
  // Read data and acknowledge
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ack <= 1'h0;
    end else begin
      cfg_ack <= cfg_req.rd || cfg_req.wr;
    end
  end

  // Other offsets read zero so an unmapped read never returns stale data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 16'h0000;
    end else if (rd_cap) begin
      cfg_rdata <= cap_word;
    end else if (rd_csr) begin
      cfg_rdata <= csr_word;
    end else begin
      cfg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Wake output
  // ----------------------------------------
  // Legacy wake drives the pin without the enable; clearing status drops it
  assign wake_gate = wake_enable_bit || legacy_magic_wake;
  assign wake_out = wake_status_flag && wake_gate;

endmodule

// [bench/power_mgmt_control_status_properties.sv]
// Purpose: Port properties of the power management registers
// Assumes: Straps hold steady around each access
// Notes: Capability bits 15:10 are not judged here
`timescale 1ns/10ps
module power_mgmt_control_status_properties (
  // Clock and resets
  input wire logic mclk, arst_n, bus_rst_n,
  // Access
  input wire power_mgmt_control_status_pkg::power_mgmt_control_status_cfg_req_t cfg_req,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_ack,
  // Straps and events
  input wire power_mgmt_control_status_pkg::power_mgmt_control_status_strap_t strap,
  input wire logic aux_power, wake_event, legacy_magic_wake, magic_packet_seen,
  // Outputs
  input wire logic wake_out,
  input wire logic [1:0] power_state_field
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence cap_rd;
    cfg_ack && $past(cfg_req.rd) && $past(cfg_req.offset) == 8'h02;
  endsequence
  sequence csr_rd;
    cfg_ack && $past(cfg_req.rd) && $past(cfg_req.offset) == 8'h04;
  endsequence
  chk_cap_fixed: assert property (cap_rd |-> cfg_rdata[9:4] == 6'h02)
    else $error("capability fixed bits wrong");
  chk_cap_version: assert property (cap_rd |-> cfg_rdata[2:0] == 3'h2)
    else $error("version code wrong");
  chk_cap_clock: assert property (cap_rd |-> cfg_rdata[3] ==
    $past(strap.clock_needed_valid && strap.clock_needed)) else $error("clock bit wrong");
  chk_scale_value: assert property (csr_rd |-> cfg_rdata[14:13] ==
    (($past(strap.manage_enable) && cfg_rdata[12:9] inside {4'h0, 4'h3, 4'h4, 4'h7}) ?
    2'h1 : 2'h0)) else $error("data scale wrong");
  chk_enable_locked: assert property ((csr_rd and !$past(strap.pm_enable)) |-> !cfg_rdata[8])
    else $error("wake enable set while locked");
  chk_clear_drops: assert property (cfg_req.wr && cfg_req.offset == 8'h04 &&
    cfg_req.wdata[15] && !wake_event && !magic_packet_seen |=> !wake_out)
    else $error("wake output kept after clear");
  chk_legacy_wake: assert property (legacy_magic_wake && magic_packet_seen |=> wake_out)
    else $error("legacy wake missing");
  chk_state_legal: assert property (power_state_field inside {2'h0, 2'h3})
    else $error("illegal power state");
  cover property (cap_rd);
  cover property ($rose(wake_out));
  cover property ($rose(bus_rst_n) && aux_power);
endmodule

// [bench/power_mgmt_control_status_host.sv]
// Purpose: Host issuing configuration reads and writes
// Assumes: Answer comes one cycle after the strobe
// Notes: Released offset and data show the inverse of the last value
`timescale 1ns/10ps
module power_mgmt_control_status_host (
  // Clock
  input wire logic mclk,
  // Access
  output power_mgmt_control_status_pkg::power_mgmt_control_status_cfg_req_t cfg_req,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_ack
);
  initial cfg_req = '0;
  task automatic xfer(input logic w, input logic [7:0] o, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge mclk);
    cfg_req <= '{rd: !w, wr: w, offset: o, wdata: d};
    @(posedge mclk);
    cfg_req <= '{rd: 1'b0, wr: 1'b0, offset: ~o, wdata: ~d};
    #1;
    // A missing answer returns a value no register can hold
    q = cfg_ack ? cfg_rdata : 16'hdead;
  endtask
endmodule

// [bench/tb.sv]
// Purpose: Self-checking bench for the power management registers
// Assumes: Host model drives the access strobes
// Notes: Capability bits 15:10 are masked off
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0, arst_n = 1'b0, bus_rst_n = 1'b1, aux_power = 1'b0;
  logic wake_event = 1'b0, legacy_magic_wake = 1'b0, magic_packet_seen = 1'b0;
  power_mgmt_control_status_pkg::power_mgmt_control_status_strap_t strap = '0;
  power_mgmt_control_status_pkg::power_mgmt_control_status_cfg_req_t cfg_req;
  logic [15:0] cfg_rdata, r;
  logic cfg_ack, wake_out;
  logic [1:0] power_state_field;
  int error_cnt = 0, comparisons = 0;
  always #20 mclk = ~mclk;
  power_mgmt_control_status_regs i_power_mgmt_control_status_regs (.mclk(mclk), .arst_n(arst_n), .bus_rst_n(bus_rst_n),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .strap(strap),
    .aux_power(aux_power), .wake_event(wake_event), .legacy_magic_wake(legacy_magic_wake),
    .magic_packet_seen(magic_packet_seen), .wake_out(wake_out),
    .power_state_field(power_state_field));
  power_mgmt_control_status_host i_power_mgmt_control_status_host (.mclk(mclk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack));
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [15:0] d);
    i_power_mgmt_control_status_host.xfer(1'b1, 8'h04, d, r);
  endtask
  task automatic rd(logic [7:0] o);
    i_power_mgmt_control_status_host.xfer(1'b0, o, 16'h0000, r);
  endtask
  task automatic set_strap(logic [3:0] v);
    @(posedge mclk);
    strap <= v;
  endtask
  task automatic ev(logic m);
    @(posedge mclk);
    if (m) magic_packet_seen <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge mclk);
    magic_packet_seen <= 1'b0;
    wake_event <= 1'b0;
    #1;
  endtask
  task automatic bus_reset(logic aux);
    @(posedge mclk);
    aux_power <= aux;
    bus_rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    bus_rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_caps();
    rd(8'h04);
    check("csr reset", r, 16'h0000);
    set_strap(4'h3);
    rd(8'h02);
    check("cap", r & 16'h03ff, 16'h002a);
    set_strap(4'h1);
    rd(8'h02);
    check("cap unloaded", r & 16'h03ff, 16'h0022);
    rd(8'h10);
    check("unmapped", r, 16'h0000);
  endtask
  task automatic t_select();
    set_strap(4'hc);
    for (int s = 0; s < 16; s++) begin
      wr(16'(s) << 9);
      rd(8'h04);
      check("select", {12'h000, r[12:9]}, 16'(s));
      check("scale", {14'h0000, r[14:13]}, (s inside {0, 3, 4, 7}) ? 16'h1 : 16'h0);
    end
    set_strap(4'h0);
    wr(16'h0b00);
    rd(8'h04);
    check("locked", r & 16'h1f00, 16'h1e00);
  endtask
  task automatic t_wake();
    set_strap(4'h8);
    wr(16'h0100);
    ev(1'b0);
    check("wake on", {15'h0000, wake_out}, 16'h1);
    wr(16'h0100);
    check("write zero", {15'h0000, wake_out}, 16'h1);
    wr(16'h8100);
    check("clear", {15'h0000, wake_out}, 16'h0);
    wr(16'h0000);
    ev(1'b0);
    check("masked", {15'h0000, wake_out}, 16'h0);
    rd(8'h04);
    check("status", {15'h0000, r[15]}, 16'h1);
    @(posedge mclk);
    legacy_magic_wake <= 1'b1;
    wr(16'h8000);
    ev(1'b1);
    check("legacy", {15'h0000, wake_out}, 16'h1);
    wr(16'h8000);
    @(posedge mclk);
    legacy_magic_wake <= 1'b0;
  endtask
  task automatic t_busrst();
    wr(16'h0103);
    check("state d3", {14'h0000, power_state_field}, 16'h3);
    wr(16'h0101);
    check("state kept", {14'h0000, power_state_field}, 16'h3);
    ev(1'b0);
    bus_reset(1'b1);
    check("aux wake", {15'h0000, wake_out}, 16'h1);
    check("state d0", {14'h0000, power_state_field}, 16'h0);
    rd(8'h04);
    check("aux enable", r & 16'h8100, 16'h8100);
    bus_reset(1'b0);
    rd(8'h04);
    check("no aux", r & 16'h8100, 16'h0000);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_caps();
    t_select();
    t_wake();
    t_busrst();
    conclude();
  end
  // Whole run is well under 400 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
endmodule
bind power_mgmt_control_status_regs power_mgmt_control_status_properties i_power_mgmt_control_status_properties (.mclk(mclk), .arst_n(arst_n),
  .bus_rst_n(bus_rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
  .strap(strap), .aux_power(aux_power), .wake_event(wake_event),
  .legacy_magic_wake(legacy_magic_wake), .magic_packet_seen(magic_packet_seen),
  .wake_out(wake_out), .power_state_field(power_state_field));
